// file: hw/ppasr_top.sv
`timescale 1ns/10ps
// Overview of operation
// (RULE1) destination bit 14 drives chip select output active when set
// (RULE2) destination bits 15 and 13..0 form the presented target address
// (RULE3) pad 14 enable hands the pad to the port, else general I/O
// (RULE4) enables 10..2 hand each address pad to the port, else general I/O
// (RULE5) enables 1..0 hand pads to address bits or latch strobes
// (RULE6) input-all-full reads 1 only when every input buffer holds data
// (RULE7) external write into a full input buffer sets sticky overflow
// (RULE8) per-buffer input flags set on fill, cleared by software read
// (RULE9) output-all-empty reads 1 only when all output buffers empty; resets 1
// (RULE10) external read of an empty output buffer sets sticky underflow
// (RULE11) per-buffer output-empty flags clear on software write; reset to 1
// (RULE12) unused status and pin-enable bits read zero and ignore writes
// (RULE13) pad configuration bit 0 picks TTL (1) or Schmitt (0) inputs
// (RULE14) pad configuration bit 1 picks seconds clock or alarm pulse out
// (RULE15) address field holds, increments or decrements after each cycle
// (RULE16) chip select function 10 makes pad 14 a chip select, else address
// (RULE17) mode field picks legacy slave, addressed slave or two master modes
// (RULE18) buffer flags ignore writes; writing 0 clears overflow and underflow
module ppasr_top #(
   parameter int BUF_COUNT = 4
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdata,
   input wire logic extWriteStbPin,
   input wire logic extReadStbPin,
   input wire logic [1:0] extAddrPin,
   input wire logic [7:0] extDataIn,
   output logic [7:0] extDataOut,
   output logic extDataOe,
   input wire logic transferDone,
   input wire logic addrLatchPhase,
   input wire logic latchHighStrobe,
   input wire logic latchLowStrobe,
   input wire logic secondsClock,
   input wire logic alarmPulse,
   output logic [15:0] targetAddress,
   output logic [14:0] padOut,
   output logic [14:0] padPortEn,
   output logic chipSelect,
   output logic csPadIsSelect,
   output logic inputThresholdTtl,
   output logic clockOutPin,
   output logic [1:0] portMode
);
   ppasr_buf_if bufBus();

   logic [15:0] dest_q;
   logic [15:0] pinEn_q;
   logic [1:0] padCfg_q;
   logic [5:0] control_q;
   logic ovf_q;
   logic unf_q;
   logic [15:0] regRdata_q;
   logic [15:0] regRdata_d;
   logic [15:0] statusWord;
   logic [1:0] wrSync1_q;
   logic [1:0] wrSync2_q;
   logic [1:0] wrSeen_q;
   logic [9:0] busSync1_q;
   logic [9:0] busSync2_q;
   logic extWrEvt;
   logic extRdEvt;
   logic slaveMode;
   logic [1:0] inPtr_q;
   logic [1:0] outPtr_q;
   logic [7:0] extDataOut_q;
   logic extDataOe_q;
   logic [15:0] targetAddress_q;
   logic [14:0] padOut_q;
   logic [14:0] padOut_d;
   logic [14:0] padPortEn_q;
   logic chipSelect_q;
   logic csPadIsSelect_q;
   logic inputThresholdTtl_q;
   logic clockOutPin_q;
   logic [1:0] portMode_q;
   ppasr_pkg::ppasr_mode_e mode;
   logic [1:0] stepMode;
   logic [1:0] csFunc;
   logic destWrite;
   logic statusWrite;

   // refused at elaboration: the status word has room for exactly four buffers
   if (BUF_COUNT != 4) begin : g_bad_count
      $error("status layout serves exactly four byte buffers");
   end

   // register page decode, used by strobes and by the read mux
   function automatic logic isBufAddr(input logic [3:0] a);
      return a[3:2] == ppasr_pkg::OFF_BUF_PAGE;
   endfunction

   function automatic logic hits(input logic [3:0] a, input logic [3:0] off);
      return a == off;
   endfunction

   assign mode = ppasr_pkg::ppasr_mode_e'(control_q[ppasr_pkg::CTL_MODE_LO +: 2]);
   assign stepMode = control_q[ppasr_pkg::CTL_STEP_LO +: 2];
   assign csFunc = control_q[ppasr_pkg::CTL_CSF_LO +: 2];
   assign destWrite = regWrite && hits(regAddr, ppasr_pkg::OFF_DEST_ADDR);
   assign statusWrite = regWrite && hits(regAddr, ppasr_pkg::OFF_STATUS);
   // only the two slave modes let the outside party touch the buffers
   assign slaveMode = mode == ppasr_pkg::MODE_LEGACY_SLAVE || mode == ppasr_pkg::MODE_ADDR_SLAVE; // [RULE17]

   // pin synchronisers; the second stage is looked at, plus a third strobe stage for edge detection
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wrSync1_q <= 2'h0;
         wrSync2_q <= 2'h0;
         wrSeen_q <= 2'h0;
         busSync1_q <= 10'h000;
         busSync2_q <= 10'h000;
      end else begin
         wrSync1_q <= {extReadStbPin, extWriteStbPin};
         wrSync2_q <= wrSync1_q;
         wrSeen_q <= wrSync2_q;
         busSync1_q <= {extAddrPin, extDataIn};
         busSync2_q <= busSync1_q;
      end
   end

   // rising edges of the synced strobes; data rides two flops behind the pins too
   assign extWrEvt = wrSync2_q[0] && !wrSeen_q[0] && slaveMode; // [RULE17]
   assign extRdEvt = wrSync2_q[1] && !wrSeen_q[1] && slaveMode; // [RULE17]

   // legacy mode with buffer stepping walks the buffers in turn
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         inPtr_q <= 2'h0;
         outPtr_q <= 2'h0;
      end else begin
         if (extWrEvt && mode == ppasr_pkg::MODE_LEGACY_SLAVE && stepMode == ppasr_pkg::STEP_BUFFERS) begin
            inPtr_q <= inPtr_q + 2'h1; // [RULE15]
         end
         if (extRdEvt && mode == ppasr_pkg::MODE_LEGACY_SLAVE && stepMode == ppasr_pkg::STEP_BUFFERS) begin
            outPtr_q <= outPtr_q + 2'h1; // [RULE15]
         end
      end
   end

   // buffer strobes toward the store
   always_comb begin
      bufBus.swRead = regRead && isBufAddr(regAddr);
      bufBus.swWrite = regWrite && isBufAddr(regAddr);
      bufBus.swIdx = regAddr[1:0];
      bufBus.swWdata = regWdata[7:0];
      bufBus.extWrite = extWrEvt;
      bufBus.extRead = extRdEvt;
      bufBus.extWdata = busSync2_q[7:0];
      bufBus.extIdx = 2'h0;
      if (mode == ppasr_pkg::MODE_ADDR_SLAVE) begin
         bufBus.extIdx = busSync2_q[9:8];
      end else if (stepMode == ppasr_pkg::STEP_BUFFERS) begin
         bufBus.extIdx = extWrEvt ? inPtr_q : outPtr_q;
      end
   end

   ppasr_buffers #(.BUF_COUNT(BUF_COUNT)) u_buffers (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .bus(bufBus.store)
   );

   // destination address; a software write wins over the automatic step
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         dest_q <= ppasr_pkg::DEST_ADDR_RST;
      end else if (destWrite) begin
         dest_q <= regWdata; // [RULE1] [RULE2]
      end else if (transferDone && stepMode == ppasr_pkg::STEP_INC) begin
         dest_q[ppasr_pkg::DEST_FIELD_W-1:0] <= dest_q[ppasr_pkg::DEST_FIELD_W-1:0] + 14'h1; // [RULE15]
      end else if (transferDone && stepMode == ppasr_pkg::STEP_DEC) begin
         dest_q[ppasr_pkg::DEST_FIELD_W-1:0] <= dest_q[ppasr_pkg::DEST_FIELD_W-1:0] - 14'h1; // [RULE15]
      end
   end

   // configuration registers; unused pin enables are never stored
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pinEn_q <= ppasr_pkg::PIN_EN_RST;
         padCfg_q <= ppasr_pkg::PAD_CFG_RST;
         control_q <= ppasr_pkg::CONTROL_RST;
      end else if (regWrite) begin
         if (hits(regAddr, ppasr_pkg::OFF_PIN_EN)) begin
            pinEn_q <= regWdata & ppasr_pkg::PIN_EN_MASK; // [RULE12]
         end
         if (hits(regAddr, ppasr_pkg::OFF_PAD_CFG)) begin
            padCfg_q <= regWdata[1:0] & ppasr_pkg::PAD_CFG_MASK; // [RULE13] [RULE14]
         end
         if (hits(regAddr, ppasr_pkg::OFF_CONTROL)) begin
            control_q <= regWdata[5:0]; // [RULE17]
         end
      end
   end

   // sticky error flags; a new event wins over a software clear
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ovf_q <= 1'b0;
         unf_q <= 1'b0;
      end else begin
         if (bufBus.overflowEvt) begin
            ovf_q <= 1'b1; // [RULE7]
         end else if (statusWrite && !regWdata[ppasr_pkg::ST_IN_OVF]) begin
            ovf_q <= 1'b0; // [RULE18]
         end
         if (bufBus.underflowEvt) begin
            unf_q <= 1'b1; // [RULE10]
         end else if (statusWrite && !regWdata[ppasr_pkg::ST_OUT_UNF]) begin
            unf_q <= 1'b0; // [RULE18]
         end
      end
   end

   // status word; the buffer flags are views of the store, not writable
   always_comb begin
      statusWord = 16'h0000; // [RULE12]
      statusWord[ppasr_pkg::ST_IN_ALL] = &bufBus.inFull; // [RULE6]
      statusWord[ppasr_pkg::ST_IN_OVF] = ovf_q;
      statusWord[ppasr_pkg::ST_IN_FULL_LO +: 4] = bufBus.inFull;
      statusWord[ppasr_pkg::ST_OUT_ALL] = &bufBus.outEmpty; // [RULE9]
      statusWord[ppasr_pkg::ST_OUT_UNF] = unf_q;
      statusWord[ppasr_pkg::ST_OUT_EMPTY_LO +: 4] = bufBus.outEmpty;
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      regRdata_d = 16'h0000;
      if (regRead) begin
         case (regAddr)
            ppasr_pkg::OFF_DEST_ADDR: regRdata_d = dest_q;
            ppasr_pkg::OFF_PIN_EN: regRdata_d = pinEn_q;
            ppasr_pkg::OFF_STATUS: regRdata_d = statusWord;
            ppasr_pkg::OFF_PAD_CFG: regRdata_d = {14'h0000, padCfg_q};
            ppasr_pkg::OFF_CONTROL: regRdata_d = {10'h000, control_q};
            default: regRdata_d = isBufAddr(regAddr) ? {8'h00, bufBus.swRdata} : 16'h0000;
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         regRdata_q <= 16'h0000;
      end else begin
         regRdata_q <= regRdata_d;
      end
   end

   // outside read data; the pad is driven one cycle behind the synced read strobe
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         extDataOut_q <= ppasr_pkg::BYTE_RST;
         extDataOe_q <= 1'b0;
      end else begin
         if (extRdEvt) begin
            extDataOut_q <= bufBus.extRdata;
         end
         extDataOe_q <= wrSync2_q[1] && slaveMode;
      end
   end

   // pad functions; pads 13..11 do not exist on the port
   always_comb begin
      padOut_d = dest_q[14:0]; // [RULE4]
      padOut_d[13:11] = 3'h0;
      if (addrLatchPhase) begin
         padOut_d[1:0] = {latchHighStrobe, latchLowStrobe}; // [RULE5]
      end
   end

   // pad and pin outputs all leave from flops
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         targetAddress_q <= ppasr_pkg::DEST_ADDR_RST;
         padOut_q <= 15'h0000;
         padPortEn_q <= 15'h0000;
         chipSelect_q <= 1'b0;
         csPadIsSelect_q <= 1'b0;
         inputThresholdTtl_q <= 1'b0;
         clockOutPin_q <= 1'b0;
         portMode_q <= 2'h0;
      end else begin
         targetAddress_q <= {dest_q[ppasr_pkg::DEST_TOP_BIT], 1'b0, dest_q[13:0]}; // [RULE2]
         padOut_q <= padOut_d;
         padPortEn_q <= pinEn_q[14:0]; // [RULE3] [RULE4] [RULE5]
         chipSelect_q <= dest_q[ppasr_pkg::DEST_CS_BIT]; // [RULE1]
         csPadIsSelect_q <= csFunc == ppasr_pkg::CSF_CHIP_SELECT; // [RULE16]
         inputThresholdTtl_q <= padCfg_q[ppasr_pkg::PAD_TTL_BIT]; // [RULE13]
         clockOutPin_q <= padCfg_q[ppasr_pkg::PAD_CLKSEL_BIT] ? secondsClock : alarmPulse; // [RULE14]
         portMode_q <= mode; // [RULE17]
      end
   end

   assign regRdata = regRdata_q;
   assign extDataOut = extDataOut_q;
   assign extDataOe = extDataOe_q;
   assign targetAddress = targetAddress_q;
   assign padOut = padOut_q;
   assign padPortEn = padPortEn_q;
   assign chipSelect = chipSelect_q;
   assign csPadIsSelect = csPadIsSelect_q;
   assign inputThresholdTtl = inputThresholdTtl_q;
   assign clockOutPin = clockOutPin_q;
   assign portMode = portMode_q;

   a_cs_from_write: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE1]
      destWrite |-> ##2 chipSelect == $past(regWdata[14], 2))
      else $error("chip select does not follow written bit");
   a_target_addr: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE2]
      destWrite ##1 !transferDone |-> ##1 targetAddress == {$past(regWdata[15], 2), 1'b0, $past(regWdata[13:0], 2)})
      else $error("target address differs from written value");
   a_pad_enables: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE3]
      regWrite && regAddr == ppasr_pkg::OFF_PIN_EN |-> ##2 padPortEn == ($past(regWdata[14:0], 2) & 15'h47FF))
      else $error("pad enables do not follow pin enable write");
   a_unused_pads: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE4]
      padPortEn[13:11] == 3'h0 && padOut[13:11] == 3'h0)
      else $error("missing pads were handed to the port");
   a_latch_pads: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE5]
      reset_n && addrLatchPhase |=> padOut[1:0] == $past({latchHighStrobe, latchLowStrobe}))
      else $error("latch strobes not on low pads");
   a_in_all_full: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE6]
      regRead && regAddr == ppasr_pkg::OFF_STATUS |=> regRdata[15] == (&$past(bufBus.inFull)))
      else $error("input-all-full flag wrong");
   a_overflow_sticks: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE7]
      bufBus.overflowEvt |=> ovf_q ##1 (ovf_q || $past(statusWrite)))
      else $error("overflow flag not sticky");
   a_out_all_empty: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE9]
      regRead && regAddr == ppasr_pkg::OFF_STATUS |=> regRdata[7] == (&$past(bufBus.outEmpty)))
      else $error("output-all-empty flag wrong");
   a_underflow_sets: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE10]
      extRdEvt && bufBus.outEmpty[bufBus.extIdx] |=> unf_q)
      else $error("underflow not flagged");
   a_status_zeros: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE12]
      regRead && regAddr == ppasr_pkg::OFF_STATUS |=> regRdata[13:12] == 2'h0 && regRdata[5:4] == 2'h0)
      else $error("unused status bits not zero");
   a_threshold: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE13]
      regWrite && regAddr == ppasr_pkg::OFF_PAD_CFG |-> ##2 inputThresholdTtl == $past(regWdata[0], 2))
      else $error("threshold select wrong");
   a_clock_out: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE14]
      reset_n |=> clockOutPin == ($past(padCfg_q[1]) ? $past(secondsClock) : $past(alarmPulse)))
      else $error("clock output source wrong");
   a_addr_step: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE15]
      transferDone && !destWrite && stepMode == ppasr_pkg::STEP_INC |=> dest_q[13:0] == $past(dest_q[13:0]) + 14'h1)
      else $error("address did not increment");
   a_addr_hold: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE15]
      reset_n && !destWrite && stepMode == ppasr_pkg::STEP_HOLD |=> $stable(dest_q))
      else $error("address moved in hold mode");
   a_cs_function: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE16]
      reset_n && csFunc == ppasr_pkg::CSF_CHIP_SELECT |=> csPadIsSelect)
      else $error("pad 14 not a chip select");
   a_master_no_ext: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE17]
      !slaveMode |-> !bufBus.extWrite && !bufBus.extRead)
      else $error("outside access in master mode");
   a_flag_no_set: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE18]
      statusWrite && !ovf_q && !bufBus.overflowEvt |=> !ovf_q)
      else $error("software set the overflow flag");
endmodule

// file: hw/ppasr_pkg.sv
package ppasr_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] OFF_DEST_ADDR = 4'h0;
   localparam logic [3:0] OFF_PIN_EN = 4'h1;
   localparam logic [3:0] OFF_STATUS = 4'h2;
   localparam logic [3:0] OFF_PAD_CFG = 4'h3;
   localparam logic [3:0] OFF_CONTROL = 4'h4;
   localparam logic [1:0] OFF_BUF_PAGE = 2'h2;
   // destination address fields
   localparam int DEST_TOP_BIT = 15;
   localparam int DEST_CS_BIT = 14;
   localparam int DEST_FIELD_W = 14;
   // pin enable fields
   localparam int PEN_CS_BIT = 14;
   localparam logic [15:0] PIN_EN_MASK = 16'h47FF;
   // buffer status fields
   localparam int ST_IN_ALL = 15;
   localparam int ST_IN_OVF = 14;
   localparam int ST_IN_FULL_LO = 8;
   localparam int ST_OUT_ALL = 7;
   localparam int ST_OUT_UNF = 6;
   localparam int ST_OUT_EMPTY_LO = 0;
   // pad configuration fields
   localparam int PAD_TTL_BIT = 0;
   localparam int PAD_CLKSEL_BIT = 1;
   localparam logic [1:0] PAD_CFG_MASK = 2'h3;
   // control fields
   localparam int CTL_MODE_LO = 0;
   localparam int CTL_STEP_LO = 2;
   localparam int CTL_CSF_LO = 4;
   localparam logic [1:0] CSF_CHIP_SELECT = 2'h2;
   // reset values
   localparam logic [15:0] DEST_ADDR_RST = 16'h0000;
   localparam logic [15:0] PIN_EN_RST = 16'h0000;
   localparam logic [1:0] PAD_CFG_RST = 2'h0;
   localparam logic [5:0] CONTROL_RST = 6'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   typedef enum logic [1:0] {MODE_LEGACY_SLAVE, MODE_ADDR_SLAVE, MODE_MASTER_SEP, MODE_MASTER_COMB} ppasr_mode_e;
   typedef enum logic [1:0] {STEP_HOLD, STEP_INC, STEP_DEC, STEP_BUFFERS} ppasr_step_e;
endpackage

// file: hw/ppasr_buf_if.sv
`timescale 1ns/10ps
interface ppasr_buf_if;
   logic swRead;
   logic swWrite;
   logic [1:0] swIdx;
   logic [7:0] swWdata;
   logic [7:0] swRdata;
   logic extWrite;
   logic extRead;
   logic [1:0] extIdx;
   logic [7:0] extWdata;
   logic [7:0] extRdata;
   logic [3:0] inFull;
   logic [3:0] outEmpty;
   logic overflowEvt;
   logic underflowEvt;
   modport regs (output swRead, swWrite, swIdx, swWdata, extWrite, extRead, extIdx, extWdata,
      input swRdata, extRdata, inFull, outEmpty, overflowEvt, underflowEvt);
   modport store (input swRead, swWrite, swIdx, swWdata, extWrite, extRead, extIdx, extWdata,
      output swRdata, extRdata, inFull, outEmpty, overflowEvt, underflowEvt);
endinterface

// file: hw/ppasr_buffers.sv
`timescale 1ns/10ps
module ppasr_buffers #(
   parameter int BUF_COUNT = 4
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   ppasr_buf_if.store bus
);
   logic [7:0] inBuf_q [BUF_COUNT];
   logic [7:0] outBuf_q [BUF_COUNT];
   logic [BUF_COUNT-1:0] inFull_q;
   logic [BUF_COUNT-1:0] outEmpty_q;

   if (BUF_COUNT != 4) begin : g_bad_count
      $error("status layout serves exactly four byte buffers");
   end

   // reads are combinational so the top can register them with the strobe
   assign bus.swRdata = inBuf_q[bus.swIdx];
   assign bus.extRdata = outBuf_q[bus.extIdx];
   assign bus.inFull = inFull_q;
   assign bus.outEmpty = outEmpty_q;
   assign bus.overflowEvt = bus.extWrite && inFull_q[bus.extIdx];
   assign bus.underflowEvt = bus.extRead && outEmpty_q[bus.extIdx];

   // per-buffer data and flags; a fresh fill wins over a same-cycle clear
   for (genvar i = 0; i < BUF_COUNT; i++) begin : g_buf
      always_ff @(posedge clk_sys) begin
         if (!reset_n) begin
            inBuf_q[i] <= ppasr_pkg::BYTE_RST;
            outBuf_q[i] <= ppasr_pkg::BYTE_RST;
            inFull_q[i] <= 1'b0;
            outEmpty_q[i] <= 1'b1; // [RULE11]
         end else begin
            if (bus.extWrite && bus.extIdx == i && !inFull_q[i]) begin
               inBuf_q[i] <= bus.extWdata;
               inFull_q[i] <= 1'b1; // [RULE8]
            end else if (bus.swRead && bus.swIdx == i) begin
               inFull_q[i] <= 1'b0; // [RULE8]
            end
            if (bus.swWrite && bus.swIdx == i) begin
               outBuf_q[i] <= bus.swWdata;
               outEmpty_q[i] <= 1'b0; // [RULE11]
            end else if (bus.extRead && bus.extIdx == i) begin
               outEmpty_q[i] <= 1'b1; // [RULE11]
            end
         end
      end
   end

   a_in_read_clears: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE8]
      bus.swRead && !(bus.extWrite && bus.extIdx == bus.swIdx) |=> !inFull_q[$past(bus.swIdx)])
      else $error("input flag not cleared by software read");
   a_out_write_fills: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE11]
      bus.swWrite |=> !outEmpty_q[$past(bus.swIdx)] && outBuf_q[$past(bus.swIdx)] == $past(bus.swWdata))
      else $error("output buffer write not taken");
endmodule

// file: bench/ppasr_ext_host.sv
`timescale 1ns/10ps
// outside host on the strobe pins; idles with both strobes low
module ppasr_ext_host (
   input wire logic clk_sys,
   output logic extWriteStbPin,
   output logic extReadStbPin,
   output logic [1:0] extAddrPin,
   output logic [7:0] extDataIn
);
   initial begin
      extWriteStbPin = 1'b0;
      extReadStbPin = 1'b0;
      extAddrPin = 2'h0;
      extDataIn = 8'h00;
   end
   // one byte per strobe; data held 3 cycles each side because the pins pass a 2-flop sync
   task automatic access(input logic wr, input logic [1:0] idx, input logic [7:0] d);
      extAddrPin <= idx;
      extDataIn <= d;
      repeat (3) @(posedge clk_sys);
      if (wr) begin
         extWriteStbPin <= 1'b1;
      end else begin
         extReadStbPin <= 1'b1;
      end
      repeat (4) @(posedge clk_sys);
      extWriteStbPin <= 1'b0;
      extReadStbPin <= 1'b0;
      repeat (3) @(posedge clk_sys);
      extDataIn <= ~d; // hold over: stale data must not look valid
   endtask
endmodule

// file: bench/tb.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin testsRun++; if ((got) !== (exp)) begin failures++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module tb;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [15:0] regWdata = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic transferDone = 1'b0;
   logic addrLatchPhase = 1'b0;
   logic latchHighStrobe = 1'b0;
   logic latchLowStrobe = 1'b0;
   logic secondsClock = 1'b0;
   logic alarmPulse = 1'b0;
   logic extWriteStbPin;
   logic extReadStbPin;
   logic [1:0] extAddrPin;
   logic [7:0] extDataIn;
   logic [7:0] extDataOut;
   logic extDataOe;
   logic chipSelect;
   logic csPadIsSelect;
   logic inputThresholdTtl;
   logic clockOutPin;
   logic [15:0] regRdata;
   logic [15:0] targetAddress;
   logic [14:0] padOut;
   logic [14:0] padPortEn;
   logic [1:0] portMode;
   int failures = 0;
   int testsRun = 0;
   // rows: offset written with all ones, value read back
   logic [3:0] rowA [6] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h2, 4'h5};
   logic [15:0] rowR [6] = '{16'hffff, 16'h47ff, 16'h0003, 16'h003f, 16'h008f, 16'h0000};
   logic [15:0] stepExp [3] = '{16'hc000, 16'hc001, 16'hffff};

   ppasr_top ppasr_top_i (.*);
   ppasr_ext_host ppasr_ext_host_i (.*);

   always #5 clk_sys = ~clk_sys;

   // three edges after a write so derived outputs have settled
   task automatic regWr(input logic [3:0] a, input logic [15:0] d);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   // read data stands only in the cycle after the strobe, so sample at its middle
   task automatic regChk(input logic [3:0] a, input logic [15:0] exp);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      @(negedge clk_sys);
      `CHK("regRdata", exp, regRdata)
      @(posedge clk_sys);
   endtask

   task automatic complete_run();
      if (failures == 0 && testsRun > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #500000;
      failures++;
      complete_run();
   end

   initial begin
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      for (int i = 0; i < 6; i++) begin
         regWr(rowA[i], 16'hffff);
         regChk(rowA[i], rowR[i]);
      end
      // chip select and presented address follow the destination
      regWr(4'h0, 16'h4005);
      `CHK("chipSelect", 1'b1, chipSelect)
      `CHK("targetAddress", 16'h0005, targetAddress)
      regWr(4'h0, 16'h8003);
      `CHK("chipSelect", 1'b0, chipSelect)
      `CHK("targetAddress", 16'h8003, targetAddress)
      regWr(4'h1, 16'h4004);
      `CHK("padPortEn", 15'h4004, padPortEn)
      `CHK("padOut", 15'h0003, padOut)
      addrLatchPhase <= 1'b1;
      latchHighStrobe <= 1'b1;
      secondsClock <= 1'b1;
      regWr(4'h3, 16'h0003);
      `CHK("padOut", 15'h0002, padOut)
      `CHK("inputThresholdTtl", 1'b1, inputThresholdTtl)
      `CHK("clockOutPin", 1'b1, clockOutPin)
      regWr(4'h3, 16'h0000);
      `CHK("inputThresholdTtl", 1'b0, inputThresholdTtl)
      `CHK("clockOutPin", 1'b0, clockOutPin)
      // every mode code, chip select function set and then cleared
      for (int m = 0; m < 4; m++) begin
         regWr(4'h4, {10'h000, 2'h2, 2'h0, m[1:0]});
         `CHK("portMode", m[1:0], portMode)
         `CHK("csPadIsSelect", 1'b1, csPadIsSelect)
      end
      regWr(4'h4, 16'h0000);
      `CHK("csPadIsSelect", 1'b0, csPadIsSelect)
      // hold, increment, and decrement across the wrap with top bits kept
      for (int s = 0; s < 3; s++) begin
         regWr(4'h0, 16'hc000);
         regWr(4'h4, {10'h000, 2'h0, s[1:0], 2'h1});
         transferDone <= 1'b1;
         @(posedge clk_sys);
         transferDone <= 1'b0;
         regChk(4'h0, stepExp[s]);
      end
      regWr(4'h4, 16'h0001);
      // outside party fills the input buffers in addressed slave mode
      for (int i = 0; i < 4; i++) begin
         ppasr_ext_host_i.access(1'b1, i[1:0], {6'h04, i[1:0]});
         if (i == 2) regChk(4'h2, 16'h078f);
      end
      regChk(4'h2, 16'h8f8f);
      ppasr_ext_host_i.access(1'b1, 2'h0, 8'hee);
      regChk(4'h2, 16'hcf8f);
      regChk(4'h8, 16'h0010);
      regChk(4'h2, 16'h4e8f);
      regWr(4'h2, 16'h0000);
      regChk(4'h2, 16'h0e8f);
      regWr(4'h9, 16'h005a);
      regChk(4'h2, 16'h0e0d);
      // drive enable is up from the third edge after the strobe until the third edge after it drops
      fork
         ppasr_ext_host_i.access(1'b0, 2'h1, 8'h00);
         begin
            repeat (7) @(posedge clk_sys);
            @(negedge clk_sys);
            `CHK("extDataOe", 1'b1, extDataOe)
         end
      join
      `CHK("extDataOut", 8'h5a, extDataOut)
      regChk(4'h2, 16'h0e8f);
      ppasr_ext_host_i.access(1'b0, 2'h2, 8'h00);
      regChk(4'h2, 16'h0ecf);
      // second reset in mid-run brings back the empty flags
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      regChk(4'h2, 16'h008f);
      regChk(4'h0, 16'h0000);
      // legacy mode with buffer stepping ignores the address pins
      regWr(4'h4, 16'h000c);
      ppasr_ext_host_i.access(1'b1, 2'h3, 8'h21);
      ppasr_ext_host_i.access(1'b1, 2'h3, 8'h22);
      regChk(4'h2, 16'h038f);
      regChk(4'h9, 16'h0022);
      complete_run();
   end
endmodule
